// [core/cpsl_top.sv]
/*
 * Chassis presence tracking, missing-set grouping, deferred identity
 * check and status LED encoding, with a classic Wishbone slave.
 * Assumes presence, module id and power pins are asynchronous; the
 * condition bundle and connection requests come from logic on clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cpsl_consts.svh"

module cpsl_top #(
    parameter int unsigned BLINK_HALF = `CPSL_BLINK_HALF_CYC
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    input  wire logic [`CPSL_NSLOT-1:0]      present_i,
    input  wire logic [`CPSL_ID_W-1:0]       module_id_i,
    output logic [`CPSL_SLOT_W-1:0]          id_sel_o,
    input  wire logic [`CPSL_CNT_W-1:0]      nv_size_i,
    output logic                             nv_write_o,
    output logic [`CPSL_CNT_W-1:0]           nv_data_o,
    input  wire logic                        conn_req_i,
    input  wire logic [`CPSL_SLOT_W-1:0]     conn_slot_i,
    output logic                             conn_done_o,
    output logic                             conn_ok_o,
    input  wire logic [`CPSL_NSLOT-1:0]      conn_close_i,
    output logic                             cfg_load_o,
    output logic [`CPSL_SLOT_W-1:0]          cfg_slot_o,
    output logic                             io_run_o,
    output logic                             removed_o,
    output logic [`CPSL_SLOT_W-1:0]          removed_slot_o,
    output logic                             minor_fault_o,
    input  wire cpsl_pkg::cpsl_cond_t        cond_i,
    input  wire logic                        dcdc_ok_i,
    input  wire logic                        field_pwr_i,
    output cpsl_pkg::cpsl_leds_t             leds_o
);
    import cpsl_pkg::*;

    localparam int N = `CPSL_NSLOT;

    function automatic logic [`CPSL_CNT_W-1:0] popcount(input logic [N-1:0] v);
        logic [`CPSL_CNT_W-1:0] c;
        c = '0;
        for (int k = 0; k < N; k++) begin
            c = c + {{(`CPSL_CNT_W-1){1'b0}}, v[k]};
        end
        return c;
    endfunction : popcount

    function automatic logic [`CPSL_SLOT_W-1:0] lowest(input logic [N-1:0] v);
        logic [`CPSL_SLOT_W-1:0] s;
        s = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (v[k]) begin
                s = k[`CPSL_SLOT_W-1:0];
            end
        end
        return s;
    endfunction : lowest

    // pin synchronisers
    logic [N-1:0]            pres_s1, pres;
    logic [`CPSL_ID_W-1:0]   id_s1, id_sync;
    logic [1:0]              pwr_s1, pwr;
    always_ff @(posedge clk_i) begin
        pres_s1 <= present_i;
        pres    <= pres_s1;
        id_s1   <= module_id_i;
        id_sync <= id_s1;
        pwr_s1  <= {dcdc_ok_i, field_pwr_i};
        pwr     <= pwr_s1;
    end

    // registers
    logic                       nokey;
    logic [`CPSL_CNT_W-1:0]     chassis;
    logic                       nv_loaded;
    logic [`CPSL_ID_W-1:0]      exp_id [N];
    logic [N-1:0]               known, blocked, active;
    logic                       run, minor, bus_off_lat, size_bad;

    wire bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr   = bus_req && wb_we_i;
    wire wr_ctrl  = bus_wr && wb_adr_i == `CPSL_OFF_CTRL && wb_sel_i[0];
    wire wr_chas  = bus_wr && wb_adr_i == `CPSL_OFF_CHASSIS && wb_sel_i[0];
    wire wr_id    = bus_wr && wb_adr_i == `CPSL_OFF_SLOT_ID && wb_sel_i[0] && wb_sel_i[2];
    wire wr_fclr  = bus_wr && wb_adr_i == `CPSL_OFF_FAULT_CLR && wb_sel_i[0];
    wire [`CPSL_SLOT_W-1:0] wr_idx =
        wb_dat_i[`CPSL_SLOTID_IDX_LSB +: `CPSL_SLOT_W];

    // presence and grouping
    wire [`CPSL_CNT_W-1:0] pres_cnt = popcount(pres);
    wire                   size_ok  = pres_cnt == chassis;
    wire [N-1:0]           missing  = known & ~pres;
    wire [N-1:0]           grp_src  = missing | blocked;
    wire [N+1:0]           grp_pad  = {1'b0, grp_src, 1'b0};
    logic [N-1:0]          in_group;
    always_comb begin
        for (int k = 0; k < N; k++) begin
            in_group[k] = grp_pad[k+1] && (grp_pad[k] || grp_pad[k+2]);
        end
    end
    wire [N-1:0] next_blocked = ((blocked & ~pres) == '0 && blocked != '0) ? '0
                              : (blocked | (in_group & missing));
    logic [N-1:0] missing_d;
    wire  [N-1:0] new_miss  = missing & ~missing_d;
    wire          pulled    = run && new_miss != '0;
    wire          pulled_cn = pulled && (new_miss & active) != '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nokey       <= `CPSL_CTRL_RST;
            chassis     <= `CPSL_CHASSIS_RST;
            nv_loaded   <= 1'b0;
            known       <= '0;
            blocked     <= '0;
            missing_d   <= '0;
            run         <= 1'b0;
            minor       <= 1'b0;
            bus_off_lat <= 1'b0;
            size_bad    <= 1'b0;
            removed_o   <= 1'b0;
            removed_slot_o <= '0;
            nv_write_o  <= 1'b0;
            nv_data_o   <= '0;
        end else begin
            nv_loaded  <= 1'b1;
            nv_write_o <= wr_chas;
            if (!nv_loaded) begin
                chassis <= nv_size_i;
            end else if (wr_chas) begin
                chassis   <= wb_dat_i[`CPSL_CNT_W-1:0];
                nv_data_o <= wb_dat_i[`CPSL_CNT_W-1:0];
            end
            if (wr_ctrl) begin
                nokey <= wb_dat_i[`CPSL_CTRL_NOKEY_BIT];
            end
            if (nv_loaded && !run && size_ok) begin
                run   <= 1'b1;
                known <= pres;
            end
            size_bad  <= nv_loaded && !run && !size_ok;
            blocked   <= run ? next_blocked : '0;
            missing_d <= missing;
            removed_o <= pulled;
            if (pulled) begin
                removed_slot_o <= lowest(new_miss);
            end
            if (pulled_cn) begin
                minor <= 1'b1;
            end else if (wr_fclr && wb_dat_i[0]) begin
                minor <= 1'b0;
            end
            if (cond_i.bus_off) begin
                bus_off_lat <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_id) begin
            exp_id[wr_idx] <= wb_dat_i[`CPSL_ID_W-1:0];
        end
    end

    // connection open: identity check deferred to the request
    cpsl_conn_st_t          cst, next_cst;
    logic [`CPSL_SLOT_W-1:0] cslot;
    logic [1:0]             wcnt;
    wire   slot_free = run && pres[conn_slot_i] && !blocked[conn_slot_i]
                    && !in_group[conn_slot_i];
    wire   id_match  = nokey || id_sync == exp_id[cslot];
    wire   chk_ok    = id_match && pres[cslot] && !blocked[cslot];

    always_comb begin
        next_cst = cst;
        case (cst)
            CPSL_C_IDLE:  if (conn_req_i && slot_free) next_cst = CPSL_C_WAIT;
            CPSL_C_WAIT:  if (wcnt == 2'(`CPSL_ID_WAIT_CYC - 1)) next_cst = CPSL_C_CHECK;
            CPSL_C_CHECK: next_cst = CPSL_C_IDLE;
            default:      next_cst = CPSL_C_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cst         <= CPSL_C_IDLE;
            cslot       <= '0;
            wcnt        <= '0;
            conn_done_o <= 1'b0;
            conn_ok_o   <= 1'b0;
            cfg_load_o  <= 1'b0;
            cfg_slot_o  <= '0;
            active      <= '0;
        end else begin
            cst         <= next_cst;
            conn_done_o <= 1'b0;
            cfg_load_o  <= 1'b0;
            wcnt        <= (cst == CPSL_C_WAIT) ? wcnt + 2'd1 : 2'd0;
            if (cst == CPSL_C_IDLE && conn_req_i) begin
                cslot <= conn_slot_i;
                if (!slot_free) begin
                    conn_done_o <= 1'b1;
                    conn_ok_o   <= 1'b0;
                end
            end
            active <= active & ~conn_close_i & ~new_miss;
            if (cst == CPSL_C_CHECK) begin
                conn_done_o <= 1'b1;
                conn_ok_o   <= chk_ok;
                if (chk_ok) begin
                    cfg_load_o    <= 1'b1;
                    cfg_slot_o    <= cslot;
                    active[cslot] <= 1'b1;
                end
            end
        end
    end

    assign id_sel_o      = cslot;
    assign io_run_o      = run;
    assign minor_fault_o = minor;

    // wishbone slave, one wait state
    logic [31:0] rd_mux;
    always_comb begin
        case (wb_adr_i)
            `CPSL_OFF_CTRL:    rd_mux = {31'h0, nokey};
            `CPSL_OFF_CHASSIS: rd_mux = {27'h0, chassis};
            `CPSL_OFF_STATUS:  rd_mux = {20'h0, pres_cnt, 3'h0, size_bad,
                                         bus_off_lat, minor, run};
            `CPSL_OFF_PRESENT: rd_mux = {16'h0, pres};
            `CPSL_OFF_BLOCKED: rd_mux = {16'h0, blocked};
            default:           rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? rd_mux : 32'h0;
        end
    end

    // shared blink timebase
    logic [31:0] bcnt;
    logic        ph;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bcnt <= '0;
            ph   <= 1'b0;
        end else if (bcnt >= BLINK_HALF - 1) begin
            bcnt <= '0;
            ph   <= ~ph;
        end else begin
            bcnt <= bcnt + 32'd1;
        end
    end

    localparam cpsl_led_t OFF = '{red: 1'b0, green: 1'b0};
    localparam cpsl_led_t RED = '{red: 1'b1, green: 1'b0};
    localparam cpsl_led_t GRN = '{red: 1'b0, green: 1'b1};
    wire cpsl_led_t alt   = '{red: ph,   green: !ph};
    wire cpsl_led_t f_red = '{red: ph,   green: 1'b0};
    wire cpsl_led_t f_grn = '{red: 1'b0, green: ph};

    wire unrec  = cond_i.checksum_fail || cond_i.ramtest_fail || cond_i.fatal_err;
    wire recov  = cond_i.fw_pending || cond_i.addr_sw_changed;
    wire bpl_fl = size_bad || missing != '0 || cond_i.io_timeout || minor;

    cpsl_leds_t next_leds;
    always_comb begin
        next_leds.health   = cond_i.selftest ? alt
                           : unrec           ? RED
                           : recov           ? f_red : GRN;
        next_leds.net_act  = !cond_i.link_up ? OFF
                           : cond_i.traffic  ? f_grn : GRN;
        next_leds.net_stat = cond_i.selftest    ? alt
                           : cond_i.dup_ip      ? RED
                           : cond_i.cip_timeout ? f_red
                           : !cond_i.ip_valid   ? OFF
                           : cond_i.cip_conn    ? GRN : f_grn;
        next_leds.bpl_stat = cond_i.selftest    ? alt
                           : (bus_off_lat || cond_i.bus_off) ? RED
                           : bpl_fl             ? f_red
                           : cond_i.fw_active   ? f_grn
                           : (run && active != '0) ? GRN : OFF;
        next_leds.sys_pwr  = (pwr == 2'b11) ? GRN : OFF;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            leds_o <= '0;
        end else begin
            leds_o <= next_leds;
        end
    end

endmodule : cpsl_top
`default_nettype wire

// [core/cpsl_consts.svh]
/*
 * Constants for the chassis presence and status LED block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef CPSL_CONSTS_SVH
`define CPSL_CONSTS_SVH

`define CPSL_NSLOT          16
`define CPSL_SLOT_W         4
`define CPSL_CNT_W          5
`define CPSL_ID_W           8

`define CPSL_OFF_CTRL       8'h00
`define CPSL_OFF_CHASSIS    8'h04
`define CPSL_OFF_STATUS     8'h08
`define CPSL_OFF_PRESENT    8'h0c
`define CPSL_OFF_BLOCKED    8'h10
`define CPSL_OFF_SLOT_ID    8'h14
`define CPSL_OFF_FAULT_CLR  8'h18

`define CPSL_CTRL_NOKEY_BIT 0
`define CPSL_SLOTID_IDX_LSB 16
`define CPSL_CTRL_RST       1'b0
`define CPSL_CHASSIS_RST    5'h00

`define CPSL_CLK_HZ         40000000
`define CPSL_BLINK_HALF_MS  500
`define CPSL_BLINK_HALF_CYC (`CPSL_CLK_HZ / 1000 * `CPSL_BLINK_HALF_MS)
`define CPSL_ID_WAIT_CYC    3

`endif

// [core/cpsl_pkg.sv]
/*
 * Types of the chassis presence and status LED block.
 * Assumes cpsl_consts.svh is on the include path.
 */
`include "cpsl_consts.svh"

package cpsl_pkg;

    typedef struct packed {
        logic red;
        logic green;
    } cpsl_led_t;

    typedef struct packed {
        logic selftest;
        logic checksum_fail;
        logic ramtest_fail;
        logic fatal_err;
        logic fw_pending;
        logic fw_active;
        logic addr_sw_changed;
        logic link_up;
        logic traffic;
        logic ip_valid;
        logic cip_conn;
        logic cip_timeout;
        logic dup_ip;
        logic bus_off;
        logic io_timeout;
    } cpsl_cond_t;

    typedef struct packed {
        cpsl_led_t health;
        cpsl_led_t net_act;
        cpsl_led_t net_stat;
        cpsl_led_t bpl_stat;
        cpsl_led_t sys_pwr;
    } cpsl_leds_t;

    typedef enum logic [1:0] {
        CPSL_C_IDLE,
        CPSL_C_WAIT,
        CPSL_C_CHECK
    } cpsl_conn_st_t;

endpackage : cpsl_pkg

// [testbench/cpsl_top_properties.sv]
/*
 * Port-level checker of cpsl_top: bus handshake, connection answers,
 * fault flags and status LED encoding.
 * Assumes one clock clk_i, synchronous reset rst_i, and a bind below.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cpsl_consts.svh"
module cpsl_top_chk (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [7:0]           wb_adr_i,
    input wire logic                 wb_ack_o,
    input wire logic                 io_run_o,
    input wire logic                 conn_req_i,
    input wire logic                 conn_done_o,
    input wire logic                 conn_ok_o,
    input wire logic                 cfg_load_o,
    input wire logic                 minor_fault_o,
    input wire cpsl_pkg::cpsl_cond_t cond_i,
    input wire logic                 dcdc_ok_i,
    input wire logic                 field_pwr_i,
    input wire cpsl_pkg::cpsl_leds_t leds_o
);
    import cpsl_pkg::*;
    logic [1:0] up;
    // outputs are only meaningful from the third edge after reset
    always_ff @(posedge clk_i) begin
        up <= rst_i ? 2'd0 : (up == 2'd3 ? up : up + 2'd1);
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || up != 2'd3);

    a_ack_one_pulse: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one cycle answer");
    a_run_gate_refuse: assert property (
        conn_req_i && !io_run_o |-> ##[1:2] (conn_done_o && !conn_ok_o))
        else $error("connection granted while io held");
    a_done_one_pulse: assert property (conn_done_o |=> !conn_done_o)
        else $error("conn done longer than one cycle");
    a_cfg_needs_ok: assert property (cfg_load_o |-> conn_done_o && conn_ok_o)
        else $error("config reload without granted connection");
    a_minor_sticky: assert property (
        minor_fault_o && !(wb_cyc_i && wb_stb_i && wb_we_i
        && wb_adr_i == `CPSL_OFF_FAULT_CLR) |=> minor_fault_o)
        else $error("minor fault dropped without clear");
    a_selftest_phase: assert property (
        cond_i.selftest |=> leds_o.health.red != leds_o.health.green
        && leds_o.health == leds_o.net_stat && leds_o.net_stat == leds_o.bpl_stat)
        else $error("self-test leds not alternating in phase");
    a_health_solid: assert property (
        !cond_i.selftest && (cond_i.checksum_fail || cond_i.ramtest_fail
        || cond_i.fatal_err) |=> leds_o.health == 2'b10)
        else $error("health not solid red");
    a_health_green: assert property (cond_i == '0 |=> leds_o.health == 2'b01)
        else $error("health not green");
    a_net_act: assert property (
        !cond_i.traffic |=> leds_o.net_act == {1'b0, $past(cond_i.link_up)})
        else $error("activity led wrong");
    a_dup_ip_red: assert property (
        !cond_i.selftest && cond_i.dup_ip |=> leds_o.net_stat == 2'b10)
        else $error("duplicate address not solid red");
    a_no_ip_off: assert property (
        !cond_i.selftest && !cond_i.ip_valid && !cond_i.dup_ip
        && !cond_i.cip_timeout |=> leds_o.net_stat == 2'b00)
        else $error("net status lit without address");
    a_bus_off_red: assert property (
        !cond_i.selftest && cond_i.bus_off |=> leds_o.bpl_stat == 2'b10)
        else $error("bus off not solid red");
    a_power_on: assert property (
        (dcdc_ok_i && field_pwr_i) [*5] |-> leds_o.sys_pwr == 2'b01)
        else $error("power led not green");
    a_power_off: assert property (!dcdc_ok_i [*5] |-> leds_o.sys_pwr == 2'b00)
        else $error("power led lit with converter down");
endmodule : cpsl_top_chk

bind cpsl_top cpsl_top_chk i_cpsl_top_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_ack_o, .io_run_o, .conn_req_i, .conn_done_o, .conn_ok_o,
    .cfg_load_o, .minor_fault_o, .cond_i, .dcdc_ok_i, .field_pwr_i, .leds_o);
`default_nettype wire

// [testbench/cpsl_bpl_model.sv]
/*
 * Backplane module model: presence pins and per-slot type codes.
 * Assumes the bench changes presence through set_mask.
 */
`timescale 1ns/100ps
`default_nettype none
module cpsl_bpl_model (
    input  wire logic [3:0] id_sel_i,
    input  wire logic       clk_i,
    output logic [15:0]     present_o,
    output logic [7:0]      module_id_o
);
    logic [7:0] kind [16];
    initial begin
        present_o = 16'h0000;
        module_id_o = 8'h00;
        // slots 2k and 2k+1 share a type, so a swap within such a pair keys fine
        for (int s = 0; s < 16; s++) kind[s] = 8'h20 + 8'(s / 2);
    end
    // empty slot gives a pattern that changes every cycle
    always @(posedge clk_i) begin
        module_id_o <= present_o[id_sel_i] ? kind[id_sel_i] : ~module_id_o;
    end
    task set_mask(input logic [15:0] m);
        @(posedge clk_i);
        present_o <= m;
    endtask : set_mask
endmodule : cpsl_bpl_model
`default_nettype wire

// [testbench/testbench.sv]
/*
 * Self-checking bench of cpsl_top with the backplane model.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cpsl_consts.svh"
module testbench;
    import cpsl_pkg::*;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        conn_req_i, conn_done_o, conn_ok_o, cfg_load_o, io_run_o;
    logic        removed_o, minor_fault_o, nv_write_o, dcdc_ok_i, field_pwr_i;
    logic [7:0]  wb_adr_i, module_id_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [15:0] present_i, conn_close_i;
    logic [3:0]  id_sel_o, conn_slot_i, cfg_slot_o, removed_slot_o, wb_sel_i;
    logic [4:0]  nv_data_o, nv_size_i;
    cpsl_cond_t  cond_i;
    cpsl_leds_t  leds_o;
    int          bad_count, samples_checked, seed, n, t;

    cpsl_top #(.BLINK_HALF(4)) i_cpsl_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .present_i, .module_id_i, .id_sel_o, .nv_size_i, .nv_write_o,
        .nv_data_o, .conn_req_i, .conn_slot_i, .conn_done_o, .conn_ok_o,
        .conn_close_i, .cfg_load_o, .cfg_slot_o, .io_run_o, .removed_o,
        .removed_slot_o, .minor_fault_o, .cond_i, .dcdc_ok_i, .field_pwr_i, .leds_o);
    cpsl_bpl_model i_cpsl_bpl_model (.id_sel_i(id_sel_o), .clk_i,
        .present_o(present_i), .module_id_o(module_id_i));

    function automatic logic [7:0] slot_type(input int s);
        return 8'h20 + 8'(s / 2);
    endfunction : slot_type
    function automatic int exp_tog();
        return 32 / 4;
    endfunction : exp_tog

    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk
    task hang(input string m);
        bad_count++;
        $display("Error at %0t: no answer from %s", $time, m);
        finish_test;
    endtask : hang
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 20) hang("bus");
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task conn(input logic [3:0] s, input logic ok);
        @(posedge clk_i);
        conn_req_i  <= 1'b1;
        conn_slot_i <= s;
        @(posedge clk_i);
        conn_req_i <= 1'b0;
        for (n = 0; n < 20 && conn_done_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 20) hang("connection");
        chk(conn_ok_o, ok, "conn result");
        chk(cfg_load_o, ok, "cfg reload");
        if (ok) chk(cfg_slot_o, s, "cfg slot");
    endtask : conn
    // toggles of one led bit over 32 cycles
    task tog(input int b);
        logic p;
        p = leds_o[b];
        t = 0;
        repeat (32) begin
            @(posedge clk_i);
            t += int'(leds_o[b] !== p);
            p = leds_o[b];
        end
    endtask : tog
    task wait_run;
        for (n = 0; n < 30 && io_run_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 30) hang("presence");
    endtask : wait_run
    task setc(input cpsl_cond_t c);
        @(posedge clk_i);
        cond_i <= c;
        repeat (3) @(posedge clk_i);
    endtask : setc

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        {bad_count, samples_checked, seed} = {32'd0, 32'd0, 32'd20263};
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, conn_req_i} = 5'b10000;
        {wb_adr_i, wb_dat_i, conn_slot_i} = '0;
        {cond_i, dcdc_ok_i, field_pwr_i} = {15'h0000, 2'b11};
        {wb_sel_i, nv_size_i, conn_close_i} = {4'hf, 5'd6, 16'h0000};
        i_cpsl_bpl_model.set_mask(16'h001f);
        repeat (7) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk(io_run_o, 1'b0, "run held with five of six");
        conn(4'd1, 1'b0);
        wb(1'b0, `CPSL_OFF_STATUS, 32'h0);
        chk(q[3], 1'b1, "size mismatch flag");
        tog(3);
        chk(t, exp_tog(), "backplane red flash");
        for (int s = 0; s < 6; s++) wb(1'b1, `CPSL_OFF_SLOT_ID,
            {12'h000, 4'(s), 8'h00, slot_type(s) ^ (s == 2 ? 8'h80 : 8'h00)});
        wb(1'b0, 8'h1c, 32'h0);
        chk(q, 32'h0, "unmapped read");
        i_cpsl_bpl_model.set_mask(16'h003f);
        wait_run;
        $display("power-up presence test done");
        wb(1'b0, `CPSL_OFF_PRESENT, 32'h0);
        chk(q, 32'h0000003f, "present mask");
        conn(4'd0, 1'b1);
        conn(4'd2, 1'b0);
        wb_sel_i <= 4'he;
        wb(1'b1, `CPSL_OFF_CTRL, 32'h1);
        wb_sel_i <= 4'hf;
        wb(1'b0, `CPSL_OFF_CTRL, 32'h0);
        chk(q, 32'h0, "keying write without lane 0");
        wb(1'b1, `CPSL_OFF_CTRL, 32'h1);
        conn(4'd2, 1'b1);
        wb(1'b1, `CPSL_OFF_CTRL, 32'h0);
        i_cpsl_bpl_model.set_mask(16'h003e);
        for (n = 0; n < 20 && removed_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 20) hang("removal");
        chk(removed_slot_o, 4'd0, "pulled slot");
        chk(minor_fault_o, 1'b1, "minor fault");
        chk(io_run_o, 1'b1, "others keep running");
        conn(4'd1, 1'b1);
        tog(3);
        chk(t, exp_tog(), "red flash after pull");
        wb(1'b0, `CPSL_OFF_BLOCKED, 32'h0);
        chk(q[15:0], 16'h0000, "single gap not blocked");
        wb(1'b1, `CPSL_OFF_FAULT_CLR, 32'h1);
        chk(minor_fault_o, 1'b0, "minor cleared");
        i_cpsl_bpl_model.set_mask(16'h0009);
        repeat (5) @(posedge clk_i);
        wb(1'b0, `CPSL_OFF_BLOCKED, 32'h0);
        chk(q[15:0], 16'h0036, "two gap sets");
        i_cpsl_bpl_model.set_mask(16'h0001);
        repeat (5) @(posedge clk_i);
        wb(1'b0, `CPSL_OFF_BLOCKED, 32'h0);
        chk(q[15:0], 16'h003e, "merged set");
        i_cpsl_bpl_model.set_mask(16'h001f);
        repeat (5) @(posedge clk_i);
        conn(4'd3, 1'b0);
        i_cpsl_bpl_model.set_mask(16'h003f);
        repeat (5) @(posedge clk_i);
        conn(4'd3, 1'b1);
        $display("grouping test done");
        repeat (60) begin
            @(posedge clk_i);
            cond_i <= 15'($random(seed)) & 15'h7ffd;
            dcdc_ok_i <= 1'($random(seed));
            field_pwr_i <= 1'($random(seed));
            repeat (6) @(posedge clk_i);
        end
        {dcdc_ok_i, field_pwr_i} <= 2'b11;
        setc(15'h0000);
        chk(leds_o[9:4], 6'h10, "normal leds");
        setc(15'h0020);
        tog(4);
        chk(t, exp_tog(), "net green flash");
        setc(15'h0030);
        chk(leds_o.net_stat, 2'b01, "net solid green");
        setc(15'h00c0);
        tog(6);
        chk(t, exp_tog(), "activity flash");
        setc(15'h0400);
        tog(9);
        chk(t, exp_tog(), "health red flash");
        wb(1'b1, `CPSL_OFF_CHASSIS, 32'h6);
        chk(nv_write_o, 1'b1, "store write pulse");
        chk(nv_data_o, 5'd6, "store write data");
        wb(1'b0, `CPSL_OFF_CHASSIS, 32'h0);
        chk(q, 32'h6, "chassis readback");
        $display("random led test done");
        rst_i <= 1'b1;
        setc(15'h0000);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_run;
        setc(15'h0200);
        tog(2);
        chk(t, exp_tog(), "update green flash");
        wb(1'b1, `CPSL_OFF_SLOT_ID, {24'h000000, slot_type(0)});
        conn(4'd0, 1'b1);
        setc(15'h0000);
        chk(leds_o.bpl_stat, 2'b01, "online green");
        @(posedge clk_i);
        conn_close_i <= 16'h0001;
        @(posedge clk_i);
        conn_close_i <= 16'h0000;
        setc(15'h0000);
        chk(leds_o.bpl_stat, 2'b00, "closed goes dark");
        setc(15'h0002);
        setc(15'h0000);
        chk(leds_o.bpl_stat, 2'b10, "bus off held");
        $display("backplane led test done");
        finish_test;
    end
endmodule : testbench
`default_nettype wire
